// [rtl/pdsd_pkg.sv]
package pdsd_pkg;

  // ----------------------------------------------------------------
  // register map (word addresses on the avalon slave, byte addr = 4*index)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_A_INT = 4'h2;
  localparam logic [3:0] REG_A_MOD = 4'h3;
  localparam logic [3:0] REG_A_FRAC = 4'h4;
  localparam logic [3:0] REG_B_INT = 4'h5;
  localparam logic [3:0] REG_B_MOD = 4'h6;
  localparam logic [3:0] REG_B_FRAC = 4'h7;
  localparam logic [3:0] REG_FB_INT = 4'h8;
  localparam logic [3:0] REG_FB_MOD = 4'h9;
  localparam logic [3:0] REG_FB_FRAC = 4'hA;
  localparam logic [3:0] REG_OUT_DIV = 4'hB;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ctrl bit positions: override enables for each divider group; p2_div ignores CTRL_OVR_OUT and always follows the register
  localparam int CTRL_OVR_A = 0;
  localparam int CTRL_OVR_B = 1;
  localparam int CTRL_OVR_FB = 2;
  localparam int CTRL_OVR_OUT = 3;

  // ----------------------------------------------------------------
  // field widths and reset values
  // ----------------------------------------------------------------
  localparam int INT_W = 8;
  localparam int MOD_W = 20;
  localparam int FRAC_W = 21;
  localparam int PDIV_W = 6;
  localparam logic [PDIV_W-1:0] P2_RESET = 6'h01;
  localparam logic [INT_W-1:0] REF_INT_MIN = 8'h01;
  localparam logic [INT_W-1:0] REF_INT_MAX = 8'h3F;
  localparam logic [INT_W-1:0] SDM_INT_MIN = 8'h04;
  localparam logic [3:0] ALT_MODE_CODE = 4'hF;

  // monitor timing: a prescaled reference is lost after this many idle cycles
  localparam int LOSS_CYCLES = 64;

  typedef enum logic [1:0] {PDSD_HOLDOVER, PDSD_ACTIVE_A, PDSD_ACTIVE_B} pdsd_sel_type;

endpackage : pdsd_pkg

// [rtl/pdsd_ref_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module pdsd_ref_monitor #(
  parameter int LOSS = 64
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // prescaled reference level, synchronous to clock
  input wire logic ref_level,
  // presence
  output logic present
);
  import pdsd_pkg::*;

  localparam int CW = $clog2(LOSS + 1);
  initial begin
    if (LOSS < 2) $error("LOSS must be at least 2");
  end

  logic prev_r;
  logic [CW-1:0] idle_r;
  logic present_r;
  wire rise = ref_level & ~prev_r;
  wire timed_out = (idle_r == CW'(LOSS));

  // a reference counts as present while rising edges keep arriving in time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      idle_r <= '0;
      present_r <= 1'b0;
    end else begin
      prev_r <= ref_level;
      if (rise) begin
        idle_r <= '0;
        present_r <= 1'b1;
      end else if (timed_out) begin
        present_r <= 1'b0;
      end else begin
        idle_r <= idle_r + CW'(1);
      end
    end
  end
  assign present = present_r;

endmodule : pdsd_ref_monitor
`default_nettype wire

// [rtl/pdsd_top.sv]
`timescale 1ns/1ns
`default_nettype none
module pdsd_top
  import pdsd_pkg::*;
#(
  parameter int LOSS = pdsd_pkg::LOSS_CYCLES
) (
  // clock and reset (clock is the crystal-derived clock)
  input wire logic clock,
  input wire logic nrst,
  // strap pins, already resolved by pull-ups
  input wire logic [3:0] ref_a_preset_straps,
  input wire logic [3:0] ref_b_preset_straps,
  input wire logic [3:0] output_preset_straps,
  // prescaled reference levels
  input wire logic reference_input_first,
  input wire logic reference_input_second,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // reference divider configuration
  output logic [pdsd_pkg::INT_W-1:0] ref_a_int,
  output logic [pdsd_pkg::MOD_W-1:0] ref_a_mod,
  output logic signed [pdsd_pkg::FRAC_W-1:0] ref_a_frac,
  output logic ref_a_sdm_en,
  output logic [pdsd_pkg::INT_W-1:0] ref_b_int,
  output logic [pdsd_pkg::MOD_W-1:0] ref_b_mod,
  output logic signed [pdsd_pkg::FRAC_W-1:0] ref_b_frac,
  output logic ref_b_sdm_en,
  output logic alt_input_mode,
  // output pll and output dividers
  output logic [pdsd_pkg::INT_W-1:0] fb_int,
  output logic [pdsd_pkg::MOD_W-1:0] fb_mod,
  output logic [pdsd_pkg::FRAC_W-1:0] fb_frac,
  output logic [pdsd_pkg::PDIV_W-1:0] p0_div,
  output logic [pdsd_pkg::PDIV_W-1:0] p1_div,
  output logic [pdsd_pkg::PDIV_W-1:0] p2_div,
  // switchover status
  output logic [1:0] active_sel,
  output logic backup_valid,
  output logic backup_align_en,
  output logic holdover
);
  import pdsd_pkg::*;

  initial begin
    if (LOSS < 2) $error("LOSS must be at least 2");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rs1_r, rs2_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  wire rst_n = rs2_r;

  // ----------------------------------------------------------------
  // preset tables
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [INT_W-1:0] n;
    logic [MOD_W-1:0] m;
    logic signed [FRAC_W-1:0] f;
  } pdsd_in_type;
  typedef struct packed {
    logic [INT_W-1:0] n;
    logic [MOD_W-1:0] m;
    logic [FRAC_W-1:0] f;
    logic [PDIV_W-1:0] p0;
  } pdsd_out_type;

  // codes are taken as pin levels; an open pin already reads 1
  // presets target a 26 MHz comparator input with a 26 MHz crystal
  function automatic pdsd_in_type in_preset(input logic [3:0] c);
    case (c)
      4'h0: in_preset = '{8'd23, 20'd130000, 21'sd110800};
      4'h1: in_preset = '{8'd24, 20'd130000, -21'sd120000};
      4'h2: in_preset = '{8'd24, 20'd154050, -21'sd114594};
      4'h3: in_preset = '{8'd24, 20'd130000, 21'sd45200};
      4'h4: in_preset = '{8'd24, 20'd166400, 21'sd96400};
      4'h5: in_preset = '{8'd25, 20'd104000, -21'sd44625};
      4'h6: in_preset = '{8'd25, 20'd198016, -21'sd42891};
      4'h7: in_preset = '{8'd25, 20'd154700, 21'sd41820};
      4'h8: in_preset = '{8'd25, 20'd154050, 21'sd74970};
      4'h9: in_preset = '{8'd25, 20'd182000, 21'sd93000};
      4'hA: in_preset = '{8'd25, 20'd153400, 21'sd108120};
      4'hB: in_preset = '{8'd26, 20'd197184, 21'sd67998};
      4'hC: in_preset = '{8'd26, 20'd146900, 21'sd83612};
      4'hD: in_preset = '{8'd27, 20'd198016, -21'sd161755};
      4'hE: in_preset = '{8'd27, 20'd197184, -21'sd115995};
      // 19.44 MHz mode: no divider preset, integer pass; zero modulus keeps the modulator off
      default: in_preset = '{8'd1, 20'd0, 21'sd0};
    endcase
  endfunction : in_preset

  function automatic pdsd_out_type out_norm(input logic [3:0] c);
    case (c)
      4'h0: out_norm = '{8'd143, 20'd520000, 21'd289600, 6'd6};
      4'h1: out_norm = '{8'd144, 20'd520000, 21'd120000, 6'd6};
      4'h2: out_norm = '{8'd144, 20'd308100, 21'd236736, 6'd6};
      4'h3: out_norm = '{8'd148, 20'd520000, 21'd22400, 6'd6};
      4'h4: out_norm = '{8'd148, 20'd465920, 21'd343840, 6'd6};
      4'h5: out_norm = '{8'd151, 20'd520000, 21'd370625, 6'd6};
      4'h6: out_norm = '{8'd152, 20'd465920, 21'd163160, 6'd6};
      4'h7: out_norm = '{8'd153, 20'd465920, 21'd377856, 6'd6};
      4'h8: out_norm = '{8'd154, 20'd328640, 21'd151168, 6'd6};
      4'h9: out_norm = '{8'd154, 20'd460096, 21'd245216, 6'd6};
      4'hA: out_norm = '{8'd155, 20'd490880, 21'd56192, 6'd6};
      4'hB: out_norm = '{8'd133, 20'd328640, 21'd119005, 6'd5};
      4'hC: out_norm = '{8'd133, 20'd470080, 21'd433856, 6'd5};
      4'hD: out_norm = '{8'd135, 20'd349440, 21'd159975, 6'd5};
      4'hE: out_norm = '{8'd136, 20'd394368, 21'd11577, 6'd5};
      default: out_norm = '{8'd149, 20'd520000, 21'd280000, 6'd5};
    endcase
  endfunction : out_norm

  function automatic pdsd_out_type out_alt(input logic [3:0] c);
    case (c)
      4'h0: out_alt = '{8'd96, 20'd777600, 21'd0, 6'd6};
      4'h1: out_alt = '{8'd96, 20'd777600, 21'd350400, 6'd6};
      4'h2: out_alt = '{8'd96, 20'd460728, 21'd373248, 6'd6};
      4'h3: out_alt = '{8'd99, 20'd777600, 21'd0, 6'd6};
      4'h4: out_alt = '{8'd99, 20'd777600, 21'd361350, 6'd6};
      4'h5: out_alt = '{8'd101, 20'd777600, 21'd353025, 6'd6};
      4'h6: out_alt = '{8'd101, 20'd870912, 21'd766638, 6'd6};
      4'h7: out_alt = '{8'd102, 20'd465920, 21'd399360, 6'd6};
      4'h8: out_alt = '{8'd103, 20'd328640, 21'd95680, 6'd6};
      4'h9: out_alt = '{8'd103, 20'd435456, 21'd148032, 6'd6};
      4'hA: out_alt = '{8'd103, 20'd917568, 21'd668736, 6'd6};
      4'hB: out_alt = '{8'd89, 20'd819072, 21'd149467, 6'd5};
      4'hC: out_alt = '{8'd89, 20'd878688, 21'd489888, 6'd5};
      4'hD: out_alt = '{8'd90, 20'd322560, 21'd188350, 6'd5};
      4'hE: out_alt = '{8'd90, 20'd546048, 21'd527555, 6'd5};
      default: out_alt = '{8'd100, 20'd777600, 21'd0, 6'd5};
    endcase
  endfunction : out_alt

  // ----------------------------------------------------------------
  // strap decode
  // ----------------------------------------------------------------
  wire pdsd_in_type pre_a = in_preset(ref_a_preset_straps);
  wire pdsd_in_type pre_b = in_preset(ref_b_preset_straps);
  wire alt_mode = (ref_a_preset_straps == ALT_MODE_CODE) | (ref_b_preset_straps == ALT_MODE_CODE);
  wire pdsd_out_type pre_o = alt_mode ? out_alt(output_preset_straps) : out_norm(output_preset_straps);

  // ----------------------------------------------------------------
  // serial-side override registers
  // ----------------------------------------------------------------
  logic [3:0] ctrl_r;
  logic [INT_W-1:0] a_int_r, b_int_r, fb_int_r;
  logic [MOD_W-1:0] a_mod_r, b_mod_r, fb_mod_r;
  logic [FRAC_W-1:0] a_frac_r, b_frac_r, fb_frac_r;
  logic [3*PDIV_W-1:0] pdiv_r;
  logic wait_r;

  // one wait state per access keeps the bus answer registered
  wire acc = (avs_read | avs_write) & wait_r;
  wire wr = avs_write & ~wait_r;
  // read data is loaded in the wait cycle so it already stands when waitrequest drops
  wire rd = avs_read & wait_r;
  wire w_ctrl = wr & (avs_address == REG_CTRL);
  wire w_aint = wr & (avs_address == REG_A_INT);
  wire w_amod = wr & (avs_address == REG_A_MOD);
  wire w_afrac = wr & (avs_address == REG_A_FRAC);
  wire w_bint = wr & (avs_address == REG_B_INT);
  wire w_bmod = wr & (avs_address == REG_B_MOD);
  wire w_bfrac = wr & (avs_address == REG_B_FRAC);
  wire w_fint = wr & (avs_address == REG_FB_INT);
  wire w_fmod = wr & (avs_address == REG_FB_MOD);
  wire w_ffrac = wr & (avs_address == REG_FB_FRAC);
  wire w_pdiv = wr & (avs_address == REG_OUT_DIV);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 4'h0;
      {a_int_r, b_int_r, fb_int_r} <= '0;
      {a_mod_r, b_mod_r, fb_mod_r} <= '0;
      {a_frac_r, b_frac_r, fb_frac_r} <= '0;
      pdiv_r <= {P2_RESET, 6'h01, 6'h06};
    end else begin
      if (w_ctrl) ctrl_r <= avs_writedata[3:0];
      if (w_aint) a_int_r <= avs_writedata[INT_W-1:0];
      if (w_amod) a_mod_r <= avs_writedata[MOD_W-1:0];
      if (w_afrac) a_frac_r <= avs_writedata[FRAC_W-1:0];
      if (w_bint) b_int_r <= avs_writedata[INT_W-1:0];
      if (w_bmod) b_mod_r <= avs_writedata[MOD_W-1:0];
      if (w_bfrac) b_frac_r <= avs_writedata[FRAC_W-1:0];
      if (w_fint) fb_int_r <= avs_writedata[INT_W-1:0];
      if (w_fmod) fb_mod_r <= avs_writedata[MOD_W-1:0];
      if (w_ffrac) fb_frac_r <= avs_writedata[FRAC_W-1:0];
      if (w_pdiv) pdiv_r <= avs_writedata[3*PDIV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // effective configuration
  // ----------------------------------------------------------------
  wire [INT_W-1:0] a_n_raw = ctrl_r[CTRL_OVR_A] ? a_int_r : pre_a.n;
  wire [MOD_W-1:0] a_m = ctrl_r[CTRL_OVR_A] ? a_mod_r : pre_a.m;
  wire [FRAC_W-1:0] a_f = ctrl_r[CTRL_OVR_A] ? a_frac_r : pre_a.f;
  wire [INT_W-1:0] b_n_raw = ctrl_r[CTRL_OVR_B] ? b_int_r : pre_b.n;
  wire [MOD_W-1:0] b_m = ctrl_r[CTRL_OVR_B] ? b_mod_r : pre_b.m;
  wire [FRAC_W-1:0] b_f = ctrl_r[CTRL_OVR_B] ? b_frac_r : pre_b.f;
  // modulator runs when modulus is nonzero and |F| is below M
  wire [FRAC_W-1:0] a_fabs = a_f[FRAC_W-1] ? FRAC_W'(-a_f) : a_f;
  wire [FRAC_W-1:0] b_fabs = b_f[FRAC_W-1] ? FRAC_W'(-b_f) : b_f;
  wire a_sdm = (a_m != '0) & (a_fabs < FRAC_W'(a_m));
  wire b_sdm = (b_m != '0) & (b_fabs < FRAC_W'(b_m));
  // clamp integer to 1..63, and to 4 or more with the modulator
  wire [INT_W-1:0] a_lo = a_sdm ? SDM_INT_MIN : REF_INT_MIN;
  wire [INT_W-1:0] b_lo = b_sdm ? SDM_INT_MIN : REF_INT_MIN;
  wire [INT_W-1:0] a_n = (a_n_raw < a_lo) ? a_lo : ((a_n_raw > REF_INT_MAX) ? REF_INT_MAX : a_n_raw);
  wire [INT_W-1:0] b_n = (b_n_raw < b_lo) ? b_lo : ((b_n_raw > REF_INT_MAX) ? REF_INT_MAX : b_n_raw);
  wire ovr_fb = ctrl_r[CTRL_OVR_FB];
  wire ovr_out = ctrl_r[CTRL_OVR_OUT];

  // ----------------------------------------------------------------
  // reference monitoring and switchover on the crystal clock
  // ----------------------------------------------------------------
  logic pres_a, pres_b;
  pdsd_ref_monitor #(.LOSS(LOSS)) u_mon_a (
    .clock(clock),
    .rst_n(rst_n),
    .ref_level(reference_input_first),
    .present(pres_a)
  );
  pdsd_ref_monitor #(.LOSS(LOSS)) u_mon_b (
    .clock(clock),
    .rst_n(rst_n),
    .ref_level(reference_input_second),
    .present(pres_b)
  );

  pdsd_sel_type sel_r, sel_nxt;
  always_comb begin
    sel_nxt = sel_r;
    case (sel_r)
      PDSD_HOLDOVER: begin
        if (pres_a) sel_nxt = PDSD_ACTIVE_A;
        else if (pres_b) sel_nxt = PDSD_ACTIVE_B;
      end
      PDSD_ACTIVE_A: begin
        if (!pres_a) sel_nxt = pres_b ? PDSD_ACTIVE_B : PDSD_HOLDOVER;
      end
      PDSD_ACTIVE_B: begin
        if (!pres_b) sel_nxt = pres_a ? PDSD_ACTIVE_A : PDSD_HOLDOVER;
      end
      default: sel_nxt = PDSD_HOLDOVER;
    endcase
  end
  // the backup is whichever present input is not active, so a returning one rejoins
  wire bk_nxt = ((sel_nxt == PDSD_ACTIVE_A) & pres_b) | ((sel_nxt == PDSD_ACTIVE_B) & pres_a);

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = UNMAPPED_READ;
    if (avs_address == REG_CTRL) rdata_nxt = {28'h0, ctrl_r};
    else if (avs_address == REG_STATUS)
      rdata_nxt = {25'h0, alt_mode, holdover, backup_valid, pres_b, pres_a, active_sel};
    else if (avs_address == REG_A_INT) rdata_nxt = {24'h0, a_n};
    else if (avs_address == REG_A_MOD) rdata_nxt = {12'h0, a_m};
    else if (avs_address == REG_A_FRAC) rdata_nxt = {{11{a_f[FRAC_W-1]}}, a_f};
    else if (avs_address == REG_B_INT) rdata_nxt = {24'h0, b_n};
    else if (avs_address == REG_B_MOD) rdata_nxt = {12'h0, b_m};
    else if (avs_address == REG_B_FRAC) rdata_nxt = {{11{b_f[FRAC_W-1]}}, b_f};
    else if (avs_address == REG_FB_INT) rdata_nxt = {24'h0, fb_int};
    else if (avs_address == REG_FB_MOD) rdata_nxt = {12'h0, fb_mod};
    else if (avs_address == REG_FB_FRAC) rdata_nxt = {11'h0, fb_frac};
    else if (avs_address == REG_OUT_DIV) rdata_nxt = {14'h0, pdiv_r};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      sel_r <= PDSD_HOLDOVER;
      backup_valid <= 1'b0;
      backup_align_en <= 1'b0;
      holdover <= 1'b1;
      active_sel <= 2'h0;
      {ref_a_int, ref_a_mod, ref_a_frac, ref_a_sdm_en} <= '0;
      {ref_b_int, ref_b_mod, ref_b_frac, ref_b_sdm_en} <= '0;
      alt_input_mode <= 1'b0;
      {fb_int, fb_mod, fb_frac} <= '0;
      p0_div <= 6'h06;
      p1_div <= 6'h01;
      p2_div <= P2_RESET;
    end else begin
      wait_r <= ~acc;
      if (rd) avs_readdata <= rdata_nxt;
      sel_r <= sel_nxt;
      active_sel <= sel_nxt;
      backup_valid <= bk_nxt;
      backup_align_en <= bk_nxt;
      holdover <= (sel_nxt == PDSD_HOLDOVER);
      ref_a_int <= a_n;
      ref_a_mod <= a_m;
      ref_a_frac <= a_f;
      ref_a_sdm_en <= a_sdm;
      ref_b_int <= b_n;
      ref_b_mod <= b_m;
      ref_b_frac <= b_f;
      ref_b_sdm_en <= b_sdm;
      alt_input_mode <= alt_mode;
      fb_int <= ovr_fb ? fb_int_r : pre_o.n;
      fb_mod <= ovr_fb ? fb_mod_r : pre_o.m;
      fb_frac <= ovr_fb ? fb_frac_r : pre_o.f;
      p0_div <= ovr_out ? pdiv_r[PDIV_W-1:0] : pre_o.p0;
      p1_div <= ovr_out ? pdiv_r[2*PDIV_W-1:PDIV_W] : 6'h01;
      p2_div <= pdiv_r[3*PDIV_W-1:2*PDIV_W];
    end
  end
  assign avs_waitrequest = wait_r;

endmodule : pdsd_top
`default_nettype wire

// [tb/pdsd_board_model.sv]
`timescale 1ns/1ns
`default_nettype none
module pdsd_board_model (
  // clock
  input wire logic clock,
  // board controls
  input wire logic [11:0] grounded,
  input wire logic en_a,
  input wire logic en_b,
  // pins seen by the device
  output logic [11:0] straps,
  output logic ref_a,
  output logic ref_b
);
  assign straps = ~grounded; // an open pin is pulled up
  // a failed source stops dead low rather than holding a last edge
  always_ff @(posedge clock) begin
    ref_a <= en_a & ~ref_a;
    ref_b <= en_b & ~ref_b;
  end
endmodule : pdsd_board_model
`default_nettype wire

// [tb/pdsd_top_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module pdsd_top_asserts
  import pdsd_pkg::*;
#(
  parameter int LOSS = 64
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // inputs watched
  input wire logic [3:0] ref_a_preset_straps,
  input wire logic [3:0] ref_b_preset_straps,
  input wire logic reference_input_first,
  input wire logic avs_read,
  input wire logic avs_write,
  // outputs watched
  input wire logic avs_waitrequest,
  input wire logic [pdsd_pkg::INT_W-1:0] ref_a_int,
  input wire logic ref_a_sdm_en,
  input wire logic alt_input_mode,
  input wire logic [pdsd_pkg::PDIV_W-1:0] p2_div,
  input wire logic [1:0] active_sel,
  input wire logic backup_valid,
  input wire logic holdover
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [2:0] up_r;
  logic [15:0] idle_r;
  wire run_ok = (up_r == 3'h4);
  wire alt_strap = (ref_a_preset_straps == 4'hF) || (ref_b_preset_straps == 4'hF);
  // ----------------------------------------
  // helpers: outputs trusted only after the internal reset lets go
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      up_r <= 3'h0;
      idle_r <= 16'h0;
    end else begin
      up_r <= run_ok ? up_r : up_r + 3'h1;
      idle_r <= reference_input_first ? 16'h0 : idle_r + {15'h0, idle_r != 16'hFFFF};
    end
  end
  sequence req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence a_up_s; run_ok && holdover && $rose(reference_input_first); endsequence
  // the divider output follows the register one edge after the write is taken
  sequence no_wr_s; !(avs_write && !avs_waitrequest); endsequence
  bus_one_wait_a: assert property (req_s |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  bus_wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  p2_hold_a: assert property (no_wr_s ##1 no_wr_s |=> $stable(p2_div))
    else $error("second output divider moved without a write");
  sel_holdover_a: assert property (holdover == (active_sel == 2'h0))
    else $error("holdover and selection disagree");
  backup_need_a: assert property (backup_valid |-> active_sel != 2'h0)
    else $error("backup without an active reference");
  alt_mode_a: assert property (run_ok |=> alt_input_mode == $past(alt_strap))
    else $error("alternate mode not following input straps");
  int_range_a: assert property (run_ok |-> ref_a_int >= REF_INT_MIN && ref_a_int <= REF_INT_MAX)
    else $error("input divider integer out of range");
  sdm_floor_a: assert property (ref_a_sdm_en |-> ref_a_int >= SDM_INT_MIN)
    else $error("modulator used with integer below floor");
  first_pick_a: assert property (a_up_s |-> ##[1:3] active_sel == 2'h1)
    else $error("present reference not made active");
  loss_bound_a: assert property (active_sel == 2'h1 |-> idle_r <= LOSS + 4)
    else $error("lost reference still active");
endmodule : pdsd_top_asserts
bind pdsd_top pdsd_top_asserts #(.LOSS(LOSS)) pdsd_top_asserts_inst (.clock, .nrst, .ref_a_preset_straps,
  .ref_b_preset_straps, .reference_input_first, .avs_read, .avs_write, .avs_waitrequest, .ref_a_int,
  .ref_a_sdm_en, .alt_input_mode, .p2_div, .active_sel, .backup_valid, .holdover);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pdsd_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] grounded = 12'h000;
  logic en_a = 1'b0;
  logic en_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [11:0] straps;
  logic ref_a, ref_b, avs_waitrequest, ref_a_sdm_en, ref_b_sdm_en, alt_input_mode;
  logic backup_valid, backup_align_en, holdover;
  logic [31:0] avs_readdata, rd;
  logic [7:0] ref_a_int, ref_b_int, fb_int;
  logic [19:0] ref_a_mod, ref_b_mod, fb_mod;
  logic signed [20:0] ref_a_frac, ref_b_frac;
  logic [20:0] fb_frac;
  logic [5:0] p0_div, p1_div, p2_div;
  logic [1:0] active_sel;
  int failures = 0;
  int tests_run = 0;
  pdsd_board_model pdsd_board_model_inst (.clock, .grounded, .en_a, .en_b, .straps, .ref_a, .ref_b);
  pdsd_top #(.LOSS(8)) pdsd_top_inst (.clock, .nrst, .ref_a_preset_straps(straps[3:0]),
    .ref_b_preset_straps(straps[7:4]), .output_preset_straps(straps[11:8]), .reference_input_first(ref_a),
    .reference_input_second(ref_b), .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .ref_a_int, .ref_a_mod, .ref_a_frac, .ref_a_sdm_en, .ref_b_int, .ref_b_mod, .ref_b_frac,
    .ref_b_sdm_en, .alt_input_mode, .fb_int, .fb_mod, .fb_frac, .p0_div, .p1_div, .p2_div, .active_sel,
    .backup_valid, .backup_align_en, .holdover);
  initial begin
    forever #20 clock = ~clock;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic give_up();
    failures++;
    $display("MISMATCH t=%0t wait ran out", $time);
    report_and_stop();
  endtask : give_up
  // request stands until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) give_up();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask : settle
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge clock);
    check(32'(p2_div), 32'h1);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
  endtask : do_reset
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_presets();
    logic [3:0] code [4] = '{4'h0, 4'h1, 4'hB, 4'hD};
    int ni [4] = '{23, 24, 26, 27};
    int nm [4] = '{130000, 130000, 197184, 198016};
    int nf [4] = '{110800, -120000, 67998, -161755};
    real fr [4] = '{622.08, 625.0, 625.0 * 255.0 / 237.0 * 66.0 / 64.0, 10518.75 / 16.0 * 255.0 / 238.0};
    real f;
    for (int i = 0; i < 4; i++) begin
      grounded <= {4'hF, ~code[3 - i], ~code[i]};
      settle();
      check(32'(ref_a_int), 32'(ni[i]));
      check(32'(ref_a_mod), 32'(nm[i]));
      check(32'(ref_a_frac), 32'(nf[i]));
      check(32'(ref_b_frac), 32'(nf[3 - i]));
      check(32'(ref_b_int), 32'(ni[3 - i]));
      check(32'(ref_b_mod), 32'(nm[3 - i]));
      f = fr[i] / (real'(ref_a_int) + 0.5 + real'(ref_a_frac) / (2.0 * real'(ref_a_mod)));
      check(32'(f > 25.99999 && f < 26.00001), 32'h1);
    end
    check({fb_int, 4'h0, fb_mod}, {8'd143, 4'h0, 20'd520000});
    check({5'h0, fb_frac, p0_div}, {5'h0, 21'd289600, 6'd6});
    check(32'(p1_div), 32'h1);
    check(32'(alt_input_mode), 32'h0);
    grounded <= 12'h0FF;
    settle();
    check({fb_int, 4'h0, fb_mod}, {8'd149, 4'h0, 20'd520000});
    check({5'h0, fb_frac, p0_div}, {5'h0, 21'd280000, 6'd5});
  endtask : t_presets
  task automatic t_alt();
    grounded <= 12'hFF0;
    settle();
    check(32'(alt_input_mode), 32'h1);
    check(32'(ref_a_sdm_en), 32'h0);
    check(32'(ref_b_sdm_en), 32'h1);
    check({fb_int, 4'h0, fb_mod}, {8'd96, 4'h0, 20'd777600});
    check({5'h0, fb_frac, p0_div}, {5'h0, 21'd0, 6'd6});
  endtask : t_alt
  task automatic t_override();
    grounded <= 12'hF0F;
    bus(1'b1, REG_A_INT, 32'd70);
    bus(1'b1, REG_A_MOD, 32'd1000);
    bus(1'b1, REG_A_FRAC, 32'd200);
    bus(1'b1, REG_CTRL, 32'h1);
    settle();
    check({ref_a_int, 4'h0, ref_a_mod}, {8'd63, 4'h0, 20'd1000});
    check(32'(ref_a_sdm_en), 32'h1);
    bus(1'b0, REG_A_INT, 32'h0);
    check(rd, 32'd63);
    bus(1'b0, 4'hC, 32'h0);
    check(rd, UNMAPPED_READ);
    bus(1'b1, REG_A_INT, 32'd3);
    settle();
    check(32'(ref_a_int), 32'd4);
    bus(1'b1, REG_OUT_DIV, {14'h0, 6'h3, 6'h1, 6'h6});
    settle();
    check(32'(p2_div), 32'h3);
    bus(1'b1, REG_CTRL, 32'h0);
    settle();
    check(32'(ref_a_int), 32'd23);
    do_reset();
  endtask : t_override
  task automatic await_sel(input logic [1:0] s, input logic b);
    int n;
    n = 0;
    while ((active_sel !== s || backup_valid !== b) && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n >= 100) give_up();
    check({30'h0, active_sel}, {30'h0, s});
  endtask : await_sel
  task automatic t_switch();
    en_a <= 1'b1;
    await_sel(2'h1, 1'b0);
    en_b <= 1'b1;
    await_sel(2'h1, 1'b1);
    check(32'(backup_align_en), 32'h1);
    en_a <= 1'b0;
    await_sel(2'h2, 1'b0);
    en_a <= 1'b1;
    await_sel(2'h2, 1'b1);
    en_a <= 1'b0;
    en_b <= 1'b0;
    await_sel(2'h0, 1'b0);
    check(32'(holdover), 32'h1);
  endtask : t_switch
  initial begin
    do_reset();
    t_presets();
    t_alt();
    t_override();
    t_switch();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
